// [hdl/qsw_defines.svh]
// constants for the quad switch command interpreter
`ifndef QSW_DEFINES_SVH
`define QSW_DEFINES_SVH

// serial frame layout, most significant bit first
`define QSW_FRAME_BITS 8
`define QSW_CTRL_MSB 7
`define QSW_CTRL_LSB 4
`define QSW_DATA_MSB 3
`define QSW_DATA_LSB 0

// control nibbles, H = 1 and L = 0
`define QSW_CMD_DIAG 4'h0
`define QSW_CMD_READBACK 4'hC
`define QSW_CMD_ECHO 4'hA
`define QSW_CMD_OR 4'h3
`define QSW_CMD_AND 4'hF

// two-bit diagnosis codes
`define QSW_DIAG_OK 2'h3
`define QSW_DIAG_LIMIT 2'h2
`define QSW_DIAG_OPEN 2'h1
`define QSW_DIAG_SGND 2'h0

// reset values
`define QSW_BYTE_RST 8'h00
`define QSW_DATA_RST 4'h0

`endif

// [hdl/qsw_pkg.sv]
// types shared by the quad switch command interpreter
package qsw_pkg;
    // latched combining operation between parallel inputs and data bits
    typedef enum logic {QSW_OP_OR, QSW_OP_AND} qsw_op_t;
    // what the next frame presents on the serial output
    typedef enum logic [1:0] {
        QSW_SO_DIAG,
        QSW_SO_READBACK,
        QSW_SO_ECHO
    } qsw_so_mode_t;
    typedef logic [1:0] qsw_code_t;
endpackage

// [hdl/qsw_diag_if.sv]
// carrier between the interpreter and its diagnosis register
interface qsw_diag_if #(parameter int NCH = 4);
    logic clear;
    logic [NCH-1:0] cond_limit;
    logic [NCH-1:0] cond_open;
    logic [NCH-1:0] cond_sgnd;
    logic [2*NCH-1:0] codes;
    logic [NCH-1:0] ch_fault;
    logic fault;

    modport core (
        output clear, cond_limit, cond_open, cond_sgnd,
        input codes, ch_fault, fault
    );
    modport diag (
        input clear, cond_limit, cond_open, cond_sgnd,
        output codes, ch_fault, fault
    );
endinterface

// [hdl/qsw_diag.sv]
// latched two-bit-per-channel diagnosis register and common fault flag
`include "qsw_defines.svh"

module qsw_diag #(
    parameter int NCH = 4
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    qsw_diag_if.diag dif
);
    qsw_pkg::qsw_code_t cur [NCH];
    qsw_pkg::qsw_code_t code_r [NCH];
    qsw_pkg::qsw_code_t code_nxt [NCH];
    qsw_pkg::qsw_code_t prev_r [NCH];
    logic [NCH-1:0] live;
    logic fault_r;
    logic fault_nxt;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // present condition, current limit ranks above the others
            always_comb begin
                if (dif.cond_limit[g]) begin
                    cur[g] = `QSW_DIAG_LIMIT;
                end else if (dif.cond_sgnd[g]) begin
                    cur[g] = `QSW_DIAG_SGND;
                end else if (dif.cond_open[g]) begin
                    cur[g] = `QSW_DIAG_OPEN;
                end else begin
                    cur[g] = `QSW_DIAG_OK;
                end
                live[g] = (cur[g] != `QSW_DIAG_OK);
                // a new error or a clear takes the present condition,
                // so an error in the clearing cycle is kept
                if ((live[g] && cur[g] != prev_r[g]) || dif.clear) begin
                    code_nxt[g] = cur[g];
                end else begin
                    code_nxt[g] = code_r[g];
                end
            end

            always_ff @(posedge i_core_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    code_r[g] <= `QSW_DIAG_OK;
                    prev_r[g] <= `QSW_DIAG_OK;
                end else begin
                    code_r[g] <= code_nxt[g];
                    prev_r[g] <= cur[g];
                end
            end

            assign dif.codes[2*g+1:2*g] = code_r[g];
            assign dif.ch_fault[g] = (code_r[g] != `QSW_DIAG_OK);

            chk_new_error_latch:
            assert property (@(posedge i_core_clk) disable iff (!i_resetn)
                (live[g] && cur[g] != prev_r[g]) |=> code_r[g] == $past(cur[g]))
                else $error("new channel error not latched");
            chk_clear_to_ok:
            assert property (@(posedge i_core_clk) disable iff (!i_resetn)
                (dif.clear && !live[g]) |=> code_r[g] == `QSW_DIAG_OK)
                else $error("diagnosis code not cleared");
        end
    endgenerate

    // flag high while any code is stored or any condition is present
    always_comb begin
        fault_nxt = (|dif.ch_fault) || (|live);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    assign dif.fault = fault_r;

    chk_fault_raise:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (|live) |=> dif.fault)
        else $error("fault flag not raised");
    chk_fault_release:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (!(|dif.ch_fault) && !(|live)) |=> !dif.fault)
        else $error("fault flag not released");
endmodule

// [hdl/qsw_core.sv]
// serial command interpreter and channel drive for the quad switch
`include "qsw_defines.svh"

module qsw_core #(
    parameter int NCH = 4
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    input wire logic [NCH-1:0] i_parallel_channel_inputs,
    input wire logic [NCH-1:0] i_parallel_inputs_connected,
    input wire logic i_input_polarity_select,
    input wire logic [NCH-1:0] i_current_limit,
    input wire logic [NCH-1:0] i_open_load,
    input wire logic [NCH-1:0] i_short_to_ground,
    output logic [NCH-1:0] o_channel_on,
    output logic o_fault_out,
    output logic o_fault_oe,
    output logic o_op_is_and,
    output logic o_echo_active
);
    localparam int FB = `QSW_FRAME_BITS;

    qsw_diag_if #(.NCH(NCH)) dif ();

    // frame edge detection, inputs already synchronous
    logic cs_q_r;
    logic sclk_q_r;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;

    // serial and command state
    logic [FB-1:0] rx_r;
    logic [FB-1:0] rx_nxt;
    logic [FB-1:0] tx_r;
    logic [FB-1:0] tx_nxt;
    logic so_r;
    logic so_nxt;
    logic so_oe_r;
    logic so_oe_nxt;
    logic echo_r;
    logic echo_nxt;
    qsw_pkg::qsw_so_mode_t mode_r;
    qsw_pkg::qsw_so_mode_t mode_nxt;
    qsw_pkg::qsw_op_t op_r;
    qsw_pkg::qsw_op_t op_nxt;
    logic [NCH-1:0] data_r;
    logic [NCH-1:0] data_nxt;
    logic [NCH-1:0] on_r;
    logic [NCH-1:0] on_nxt;

    logic [3:0] ctrl;
    logic [NCH-1:0] par_active;
    logic [FB-1:0] diag_byte;
    logic [FB-1:0] readback_byte;

    assign ctrl = rx_r[`QSW_CTRL_MSB:`QSW_CTRL_LSB];

    // edges of SCLK count only inside a frame
    assign cs_fall = cs_q_r && !i_cs_n;
    assign cs_rise = !cs_q_r && i_cs_n;
    assign sclk_fall = sclk_q_r && !i_sclk && !i_cs_n;
    assign sclk_rise = !sclk_q_r && i_sclk && !i_cs_n;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cs_q_r <= 1'b1;
            sclk_q_r <= 1'b0;
        end else begin
            cs_q_r <= i_cs_n;
            sclk_q_r <= i_sclk;
        end
    end

    // polarity pin selects the active level; a floating input is off
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_par
            assign par_active[g] = i_parallel_inputs_connected[g] &&
                !(i_parallel_channel_inputs[g] ^ i_input_polarity_select);
        end
    endgenerate

    // outgoing bytes: full diagnosis, or inputs plus one fault bit each
    assign diag_byte = dif.codes;
    assign readback_byte = {par_active, ~dif.ch_fault};

    // diagnosis register hookup
    assign dif.clear = cs_rise;
    assign dif.cond_limit = i_current_limit;
    assign dif.cond_open = i_open_load;
    assign dif.cond_sgnd = i_short_to_ground;

    qsw_diag #(.NCH(NCH)) u_diag (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .dif(dif)
    );

    // serial engine and command decode
    always_comb begin
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        so_nxt = so_r;
        so_oe_nxt = so_oe_r;
        echo_nxt = echo_r;
        mode_nxt = mode_r;
        op_nxt = op_r;
        data_nxt = data_r;
        if (cs_fall) begin
            // snapshot taken at frame start; later faults wait a frame
            so_oe_nxt = 1'b1;
            rx_nxt = `QSW_BYTE_RST;
            echo_nxt = (mode_r == qsw_pkg::QSW_SO_ECHO);
            if (mode_r == qsw_pkg::QSW_SO_READBACK) begin
                tx_nxt = readback_byte;
            end else begin
                tx_nxt = diag_byte;
            end
            so_nxt = echo_nxt ? i_si : tx_nxt[FB-1];
        end else if (cs_rise) begin
            so_oe_nxt = 1'b0;
            echo_nxt = 1'b0;
            mode_nxt = qsw_pkg::QSW_SO_DIAG;
            case (ctrl)
                `QSW_CMD_DIAG: begin
                    // outputs and operation untouched
                    mode_nxt = qsw_pkg::QSW_SO_DIAG;
                end
                `QSW_CMD_READBACK: begin
                    mode_nxt = qsw_pkg::QSW_SO_READBACK;
                end
                `QSW_CMD_ECHO: begin
                    mode_nxt = qsw_pkg::QSW_SO_ECHO;
                end
                `QSW_CMD_OR: begin
                    op_nxt = qsw_pkg::QSW_OP_OR;
                    data_nxt = rx_r[NCH-1:0];
                end
                `QSW_CMD_AND: begin
                    op_nxt = qsw_pkg::QSW_OP_AND;
                    data_nxt = rx_r[NCH-1:0];
                end
                default: begin
                    data_nxt = rx_r[NCH-1:0];
                end
            endcase
        end else if (!i_cs_n) begin
            if (echo_r) begin
                so_nxt = i_si;
            end else if (sclk_rise) begin
                so_nxt = tx_r[FB-2];
                tx_nxt = {tx_r[FB-2:0], 1'b0};
            end
            if (sclk_fall) begin
                rx_nxt = {rx_r[FB-2:0], i_si};
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_r <= `QSW_BYTE_RST;
            tx_r <= `QSW_BYTE_RST;
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
            echo_r <= 1'b0;
            mode_r <= qsw_pkg::QSW_SO_DIAG;
            op_r <= qsw_pkg::QSW_OP_OR;
            data_r <= `QSW_DATA_RST;
        end else begin
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            so_r <= so_nxt;
            so_oe_r <= so_oe_nxt;
            echo_r <= echo_nxt;
            mode_r <= mode_nxt;
            op_r <= op_nxt;
            data_r <= data_nxt;
        end
    end

    // channel drive follows parallel inputs every cycle, so pwm on the
    // inputs passes through with one cycle of latency
    always_comb begin
        if (op_r == qsw_pkg::QSW_OP_AND) begin
            on_nxt = par_active & data_r;
        end else begin
            on_nxt = par_active | data_r;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            on_r <= '0;
        end else begin
            on_r <= on_nxt;
        end
    end

    // outputs
    assign o_channel_on = on_r;
    assign o_so = so_r;
    assign o_so_oe = so_oe_r;
    assign o_fault_out = 1'b0; // open drain only ever pulls low
    assign o_fault_oe = dif.fault;
    assign o_op_is_and = (op_r == qsw_pkg::QSW_OP_AND);
    assign o_echo_active = echo_r;

    chk_or_combine:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (op_r == qsw_pkg::QSW_OP_OR) |=>
            o_channel_on == ($past(par_active) | $past(data_r)))
        else $error("OR combine wrong");

    chk_reset_or:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $rose(i_resetn) |-> (op_r == qsw_pkg::QSW_OP_OR) && data_r == '0)
        else $error("operation after reset is not OR");

    chk_or_held:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (op_r == qsw_pkg::QSW_OP_OR && !(cs_rise && ctrl == `QSW_CMD_AND))
            |=> op_r == qsw_pkg::QSW_OP_OR)
        else $error("OR lost without AND command");

    chk_and_combine:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (cs_rise && ctrl == `QSW_CMD_AND) |=>
            o_op_is_and ##1 o_channel_on == ($past(par_active) & data_r))
        else $error("AND command not applied");

    chk_and_held:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (op_r == qsw_pkg::QSW_OP_AND && !(cs_rise && ctrl == `QSW_CMD_OR))
            |=> op_r == qsw_pkg::QSW_OP_AND)
        else $error("AND lost without OR command");

    chk_other_data:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (cs_rise && ctrl != `QSW_CMD_DIAG && ctrl != `QSW_CMD_READBACK &&
            ctrl != `QSW_CMD_ECHO) |=> data_r == $past(rx_r[NCH-1:0]))
        else $error("data bits not taken");

    chk_so_release:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_q_r |-> !o_so_oe)
        else $error("SO driven with select high");

    chk_so_drive:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_fall ##1 !i_cs_n |-> o_so_oe)
        else $error("SO not driven in frame");

    chk_diag_only:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (cs_rise && ctrl == `QSW_CMD_DIAG) |=>
            data_r == $past(data_r) && op_r == $past(op_r))
        else $error("diagnosis-only changed state");

    chk_readback_byte:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (cs_fall && mode_r == qsw_pkg::QSW_SO_READBACK) |=>
            tx_r == $past(readback_byte) && o_so == $past(readback_byte[FB-1]))
        else $error("read-back byte wrong");

    chk_echo_path:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (echo_r && !i_cs_n && !cs_fall) |=> o_so == $past(i_si))
        else $error("echo does not follow SI");

    // a one-clock select gap may open the next echo frame right away
    chk_echo_once:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_rise |=> !echo_r)
        else $error("echo not ended with frame");

    chk_echo_start:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $rose(echo_r) |->
            $past(cs_fall && mode_r == qsw_pkg::QSW_SO_ECHO))
        else $error("echo opened outside an echo frame");

    chk_floating_off:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_parallel_inputs_connected == '0 && data_r == '0) |=>
            o_channel_on == '0)
        else $error("floating inputs turned a channel on");
endmodule

// [dv/qsw_host.sv]
// serial master model that clocks frames into the quad switch
module qsw_host #(
    parameter int SETTLE = 20
) (
    input wire logic i_core_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_si
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle: deselected, clock low so select edges never clock
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
    end

    // one msb-first frame; so sampled before each rise, si held past fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        int i;
        @(negedge i_core_clk);
        o_cs_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        for (i = 7; i >= 0; i--) begin
            o_si = tx[i];
            repeat (2) @(negedge i_core_clk);
            rx[i] = i_so_oe ? i_so : 1'bx;
            o_sclk = 1'b1;
            repeat (2) @(negedge i_core_clk);
            o_sclk = 1'b0;
            repeat (2) @(negedge i_core_clk);
        end
        o_cs_n = 1'b1;
        o_si = ~o_si; // ignored while deselected
        repeat (3) @(negedge i_core_clk);
    endtask

    // send, let outputs settle, resend and keep the answer
    task automatic diag_read(input logic [7:0] cmd, output logic [7:0] rx);
        logic [7:0] dummy;
        xfer(cmd, dummy);
        repeat (SETTLE) @(negedge i_core_clk);
        xfer(cmd, rx);
    endtask
endmodule

// [dv/quad_switch_mode_and_diagnosis_test.sv]
// self-checking bench for the quad switch command interpreter
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module quad_switch_mode_and_diagnosis_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rstn, cs_n, sclk, si, so, so_oe, pol;
    logic fout, foe, is_and, echo, fault_pin;
    logic [3:0] pin, conn, lim, opn, sgnd, chon;
    logic [7:0] rx;
    int errors = 0;
    int n_checks = 0;

    // open-drain fault line with its pull-up
    assign fault_pin = foe ? fout : 1'b1;

    qsw_core #(.NCH(4)) dut (
        .i_core_clk(clk), .i_resetn(rstn), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_si(si), .o_so(so), .o_so_oe(so_oe),
        .i_parallel_channel_inputs(pin),
        .i_parallel_inputs_connected(conn),
        .i_input_polarity_select(pol), .i_current_limit(lim),
        .i_open_load(opn), .i_short_to_ground(sgnd),
        .o_channel_on(chon), .o_fault_out(fout), .o_fault_oe(foe),
        .o_op_is_and(is_and), .o_echo_active(echo)
    );

    qsw_host #(.SETTLE(20)) host (
        .i_core_clk(clk), .i_so(so), .i_so_oe(so_oe),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si)
    );

    // 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wait2();
        repeat (2) @(negedge clk);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // defaults: parallel inputs alone drive channels
    task automatic t_reset();
        `CHK(chon, 4'h5)
        `CHK(is_and, 1'b0)
        `CHK(so_oe, 1'b0)
        `CHK(fault_pin, 1'b1)
    endtask

    // or, then an unnamed nibble keeps or
    task automatic t_or();
        pin = 4'h2;
        host.xfer(8'h39, rx);
        `CHK(chon, 4'hB)
        `CHK(rx, 8'hFF)
        host.xfer(8'h7D, rx);
        `CHK(chon, 4'hF)
        `CHK(is_and, 1'b0)
    endtask

    // and, unnamed nibble keeps and, diagnosis-only leaves all alone
    task automatic t_and();
        pin = 4'h6;
        host.xfer(8'hF2, rx);
        `CHK(chon, 4'h2)
        `CHK(is_and, 1'b1)
        host.xfer(8'h9D, rx);
        `CHK(chon, 4'h4)
        host.xfer(8'h0F, rx);
        pin = 4'hE;
        wait2();
        `CHK(chon, 4'hC)
        `CHK(is_and, 1'b1)
        host.xfer(8'h30, rx);
        `CHK(is_and, 1'b0)
    endtask

    // mixed faults latched, read, cleared on select rise
    task automatic t_diag();
        opn = 4'h1;
        wait2();
        `CHK(fault_pin, 1'b0)
        opn = 4'h2;
        lim = 4'h1;
        sgnd = 4'h4;
        host.diag_read(8'h00, rx);
        `CHK(rx, 8'hC6)
        lim = 4'h0;
        opn = 4'h0;
        sgnd = 4'h0;
        wait2();
        `CHK(fault_pin, 1'b0)
        host.xfer(8'h00, rx);
        `CHK(rx, 8'hC6)
        `CHK(fault_pin, 1'b1)
        host.xfer(8'h00, rx);
        `CHK(rx, 8'hFF)
    endtask

    // input read-back with one-bit faults, then normal again
    task automatic t_readback();
        pin = 4'hA;
        opn = 4'h2;
        wait2();
        host.xfer(8'hC0, rx);
        host.xfer(8'h00, rx);
        `CHK(rx, 8'hAD)
        opn = 4'h0;
        host.xfer(8'h00, rx);
        `CHK(rx, 8'hF7)
        host.xfer(8'h00, rx);
    endtask

    // echo lasts exactly one select period
    task automatic t_echo();
        host.xfer(8'hA0, rx);
        host.xfer(8'h05, rx);
        `CHK(rx, 8'h05)
        host.xfer(8'h00, rx);
        `CHK(rx, 8'hFF)
        `CHK(echo, 1'b0)
        `CHK(so_oe, 1'b0)
    endtask

    // reset in mid-run drops a latched and, inputs alone drive again
    task automatic t_rereset();
        host.xfer(8'hF5, rx);
        `CHK(is_and, 1'b1)
        `CHK(chon, 4'h0)
        rstn = 1'b0;
        wait2();
        `CHK(chon, 4'h0)
        `CHK(is_and, 1'b0)
        rstn = 1'b1;
        wait2();
        `CHK(chon, 4'hA)
        `CHK(is_and, 1'b0)
    endtask

    // low-active inputs, then unconnected inputs stay off
    task automatic t_pol();
        pol = 1'b0;
        pin = 4'h3;
        wait2();
        `CHK(chon, 4'hC)
        conn = 4'h0;
        wait2();
        `CHK(chon, 4'h0)
        pol = 1'b1;
        pin = 4'hF;
        wait2();
        `CHK(chon, 4'h0)
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        pin = 4'h5;
        conn = 4'hF;
        pol = 1'b1;
        lim = 4'h0;
        opn = 4'h0;
        sgnd = 4'h0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        wait2();
        t_reset();
        t_or();
        t_and();
        t_diag();
        t_readback();
        t_echo();
        t_rereset();
        t_pol();
        final_report();
    end
endmodule
